//--- hw/pmsc_pkg.sv
// Constants and carrier types for the power management status and control block.
// Assumes a single 50 MHz bus clock and an 8-bit register port.
package pmsc_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [3:0] PMSC_ADDR_CTRL2 = 4'h0;
  localparam int PMSC_BIT_WARN_FLAG = 7;
  localparam int PMSC_BIT_WARN_ACK = 6;
  localparam int PMSC_BIT_DETECT_TRIP = 5;
  localparam int PMSC_BIT_WARN_TRIP = 4;
  localparam int PMSC_BIT_PPD_FLAG = 3;
  localparam int PMSC_BIT_PPD_ACK = 2;
  localparam int PMSC_BIT_PD_ENABLE = 1;
  localparam int PMSC_BIT_PPD_SELECT = 0;
  localparam logic [7:0] PMSC_RESET_VALUE = 8'h00;
  localparam logic [7:0] PMSC_UNMAPPED_READ = 8'h00;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef enum logic {
    PMSC_TRIP_LOW,
    PMSC_TRIP_HIGH
  } pmsc_trip_t;

  typedef struct packed {
    logic power_down_enable;
    logic partial_pd_select;
  } pmsc_stop_cfg_t;

  typedef struct packed {
    logic por;
    logic other;
  } pmsc_reset_src_t;

endpackage : pmsc_pkg

//--- hw/pmsc_write_once.sv
// One write-once control bit: the first write since reset is taken, later ones are ignored.
// Assumes reset_in covers every reset source for this bit.
`timescale 1ns/1ns
module pmsc_write_once
  import pmsc_pkg::*;
(
  input wire logic clk_in, // Bus clock.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic wr_in, // Register write strobe.
  input wire logic data_in, // Written value.
  output logic value_out // Held value.
);

  logic value_q;
  logic done_q;
  wire logic take = wr_in && !done_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      value_q <= 1'b0;
      done_q <= 1'b0;
    end else if (take) begin
      value_q <= data_in;
      done_q <= 1'b1;
    end
  end

  assign value_out = value_q;

  a_second_write_ignored: assert property (@(posedge clk_in) disable iff (reset_in)
      (done_q && wr_in) |=> $stable(value_q)) else $error("write-once bit changed twice");

endmodule : pmsc_write_once

//--- hw/pmsc_ctrl2.sv
// Power management status and control register two: warning and recovery flags, trip selects,
// write-once stop-mode controls.
// Assumes monitor inputs are synchronous to clk_in and that reset sources are one-cycle or longer levels.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns

// What this block does
// - Bit 7 is a read-only sticky warning flag, kept after the warning ends.
// - Flag sets when supply is below warning point, including as reset ends.
// - Writing 1 to bit 6 clears the warning flag only without a present warning.
// - Bit 5 selects detector trip point: 0 low, 1 high.
// - Bit 4 selects warning monitor trip point, low or high.
// - Bit 3 reads 1 after recovery from partial power down, else 0.
// - Writing 1 to bit 2 clears the partial power down recovery flag.
// - Bit 1 is write-once power down enable; later writes ignored.
// - Bit 0 is write-once mode select: 0 full, 1 partial power down.
module pmsc_ctrl2
  import pmsc_pkg::*;
(
  input wire logic clk_in, // Bus clock, 50 MHz.
  input wire logic reset_in, // Any reset, synchronous, active high.
  input wire logic por_reset_in, // Power-on reset, asserted together with reset_in.
  input wire logic [3:0] addr_in, // Register address.
  input wire logic [7:0] wdata_in, // Write data.
  input wire logic wr_in, // Write strobe.
  input wire logic rd_in, // Read strobe.
  output logic [7:0] rdata_out, // Read data, valid the cycle after rd_in.
  input wire logic warn_present_in, // Supply below the warning trip point.
  input wire logic ppd_recovered_in, // Pulse: woke from partial power down.
  output logic detect_trip_out, // Detector trip point select.
  output logic warn_trip_out, // Warning monitor trip point select.
  output logic power_down_enable_out, // Power down stop modes allowed.
  output logic partial_pd_select_out // 1 partial, 0 full power down.
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic hit = (addr_in == PMSC_ADDR_CTRL2);
  wire logic wr_hit = wr_in && hit;
  // Only one address is mapped; any other address ignores writes and reads as zero.
  wire logic warn_ack = wr_hit && wdata_in[PMSC_BIT_WARN_ACK];
  wire logic ppd_ack = wr_hit && wdata_in[PMSC_BIT_PPD_ACK];

  logic low_volt_warn_flag_q;
  logic partial_pd_recovery_flag_q;
  pmsc_trip_t detect_trip_select_q;
  pmsc_trip_t warn_trip_select_q;
  logic pd_enable_value;
  logic ppd_select_value;
  logic stop_written_q;
  logic [7:0] rdata_q;

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Holding the flag while the warning stays present makes an ack during a warning harmless.
  wire logic warn_flag_d = warn_present_in
      || (low_volt_warn_flag_q && !warn_ack);

  // Recovery event wins over a same-cycle acknowledge so it is never lost.
  wire logic ppd_flag_d = ppd_recovered_in || (partial_pd_recovery_flag_q && !ppd_ack);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      low_volt_warn_flag_q <= 1'b0;
      partial_pd_recovery_flag_q <= 1'b0;
    end else begin
      low_volt_warn_flag_q <= warn_flag_d;
      partial_pd_recovery_flag_q <= ppd_flag_d;
    end
  end

  // ****************************************************************
  // Trip selects
  // ****************************************************************
  // Only power-on clears them, so a low-voltage reset keeps the chosen thresholds.
  // A write that meets any reset is dropped, so it can never overtake the reset value.
  always_ff @(posedge clk_in) begin
    if (por_reset_in) begin
      detect_trip_select_q <= PMSC_TRIP_LOW;
      warn_trip_select_q <= PMSC_TRIP_LOW;
    end else if (wr_hit && !reset_in) begin
      detect_trip_select_q <= pmsc_trip_t'(wdata_in[PMSC_BIT_DETECT_TRIP]);
      warn_trip_select_q <= pmsc_trip_t'(wdata_in[PMSC_BIT_WARN_TRIP]);
    end
  end

  // ****************************************************************
  // Write-once stop controls
  // ****************************************************************
  // Any write to the register spends the single write of both cells, acknowledge-only writes included,
  // so boot code has to set the stop controls in its very first write to the register.
  pmsc_write_once u_pd_enable (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_in(wr_hit),
    .data_in(wdata_in[PMSC_BIT_PD_ENABLE]),
    .value_out(pd_enable_value)
  );

  pmsc_write_once u_ppd_select (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_in(wr_hit),
    .data_in(wdata_in[PMSC_BIT_PPD_SELECT]),
    .value_out(ppd_select_value)
  );

  // Both controls travel together to the read path and the outputs.
  wire pmsc_stop_cfg_t stop_cfg = pmsc_stop_cfg_t'({pd_enable_value, ppd_select_value});

  // ****************************************************************
  // Read path and outputs
  // ****************************************************************
  wire logic [7:0] reg_view = {low_volt_warn_flag_q, 1'b0,
      logic'(detect_trip_select_q), logic'(warn_trip_select_q),
      partial_pd_recovery_flag_q, 1'b0,
      stop_cfg.power_down_enable, stop_cfg.partial_pd_select};
  wire logic [7:0] rdata_d = !rd_in ? PMSC_RESET_VALUE : (hit ? reg_view : PMSC_UNMAPPED_READ);

  // Read data fall back to zero outside the answer cycle, so a late sample never shows a live value.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= PMSC_RESET_VALUE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;
  assign detect_trip_out = logic'(detect_trip_select_q);
  assign warn_trip_out = logic'(warn_trip_select_q);
  assign power_down_enable_out = stop_cfg.power_down_enable;
  // The mode select is passed on even while power down is disabled; the stop controller qualifies it
  // with the enable, which keeps this output a plain register.
  assign partial_pd_select_out = stop_cfg.partial_pd_select;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_warn_flag_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
      (low_volt_warn_flag_q && !warn_ack) |=> low_volt_warn_flag_q) else $error("warning flag dropped");
  a_warn_flag_sets: assert property (@(posedge clk_in) disable iff (reset_in)
      warn_present_in |=> low_volt_warn_flag_q) else $error("warning flag not set");
  a_warn_ack_clears: assert property (@(posedge clk_in) disable iff (reset_in)
      (warn_ack && !warn_present_in) |=> !low_volt_warn_flag_q) else $error("warning ack ignored");
  a_detect_trip_write: assert property (@(posedge clk_in) disable iff (reset_in)
      wr_hit |=> detect_trip_out == $past(wdata_in[PMSC_BIT_DETECT_TRIP])) else $error("detect trip wrong");
  a_warn_trip_write: assert property (@(posedge clk_in) disable iff (reset_in)
      wr_hit |=> warn_trip_out == $past(wdata_in[PMSC_BIT_WARN_TRIP])) else $error("warn trip wrong");
  a_ppd_flag_sets: assert property (@(posedge clk_in) disable iff (reset_in)
      ppd_recovered_in |=> partial_pd_recovery_flag_q) else $error("recovery flag not set");
  a_ppd_ack_clears: assert property (@(posedge clk_in) disable iff (reset_in)
      (ppd_ack && !ppd_recovered_in) |=> !partial_pd_recovery_flag_q) else $error("recovery ack ignored");
  a_trip_kept_reset: assert property (@(posedge clk_in)
      (reset_in && !por_reset_in) |=> $stable(detect_trip_out) && $stable(warn_trip_out))
      else $error("trip select lost on reset");
  a_ack_reads_zero: assert property (@(posedge clk_in) disable iff (reset_in)
      rd_in |=> rdata_out[PMSC_BIT_WARN_ACK] == 1'b0 && rdata_out[PMSC_BIT_PPD_ACK] == 1'b0)
      else $error("ack bit read as one");

  // ****************************************************************
  // Checks on the status flags and reset
  // ****************************************************************
  // The recovery flag must survive until software acknowledges it, or a wakeup would go unseen.
  a_ppd_flag_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
      (partial_pd_recovery_flag_q && !ppd_ack) |=> partial_pd_recovery_flag_q)
      else $error("recovery flag dropped");
  a_warn_ack_blocked: assert property (@(posedge clk_in) disable iff (reset_in)
      (warn_ack && warn_present_in) |=> low_volt_warn_flag_q)
      else $error("warning cleared while present");
  a_ppd_set_wins: assert property (@(posedge clk_in) disable iff (reset_in)
      (ppd_ack && ppd_recovered_in) |=> partial_pd_recovery_flag_q)
      else $error("recovery lost to acknowledge");
  a_reset_clears_state: assert property (@(posedge clk_in)
      reset_in |=> !low_volt_warn_flag_q && !partial_pd_recovery_flag_q
          && !power_down_enable_out && !partial_pd_select_out)
      else $error("state kept over reset");
  a_por_clears_trips: assert property (@(posedge clk_in)
      por_reset_in |=> !detect_trip_out && !warn_trip_out)
      else $error("trip select kept over power-on reset");

  // ****************************************************************
  // Checks on the write-once controls
  // ****************************************************************
  // Tracks the first register write since reset apart from the write-once cells, so the checks below
  // catch a cell that locks too early or too late.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stop_written_q <= 1'b0;
    end else if (wr_hit) begin
      stop_written_q <= 1'b1;
    end
  end

  a_stop_first_write: assert property (@(posedge clk_in) disable iff (reset_in)
      (wr_hit && !stop_written_q) |=> power_down_enable_out == $past(wdata_in[PMSC_BIT_PD_ENABLE])
          && partial_pd_select_out == $past(wdata_in[PMSC_BIT_PPD_SELECT]))
      else $error("first stop control write lost");
  a_stop_cfg_locked: assert property (@(posedge clk_in) disable iff (reset_in)
      (wr_hit && stop_written_q) |=> $stable(power_down_enable_out) && $stable(partial_pd_select_out))
      else $error("write-once control changed");

  // ****************************************************************
  // Checks on the read path
  // ****************************************************************
  // Every readable bit must show the state of the cycle in which the read was taken.
  a_read_flag_bits: assert property (@(posedge clk_in) disable iff (reset_in)
      (rd_in && hit) |=> rdata_out[PMSC_BIT_WARN_FLAG] == $past(low_volt_warn_flag_q)
          && rdata_out[PMSC_BIT_PPD_FLAG] == $past(partial_pd_recovery_flag_q))
      else $error("flag read back wrong");
  a_read_trip_bits: assert property (@(posedge clk_in) disable iff (reset_in)
      (rd_in && hit) |=> rdata_out[PMSC_BIT_DETECT_TRIP] == $past(detect_trip_out)
          && rdata_out[PMSC_BIT_WARN_TRIP] == $past(warn_trip_out))
      else $error("trip select read back wrong");
  a_read_stop_bits: assert property (@(posedge clk_in) disable iff (reset_in)
      (rd_in && hit) |=> rdata_out[PMSC_BIT_PD_ENABLE] == $past(power_down_enable_out)
          && rdata_out[PMSC_BIT_PPD_SELECT] == $past(partial_pd_select_out))
      else $error("stop control read back wrong");

endmodule : pmsc_ctrl2

//--- bench/pmsc_monitor_model.sv
// Model of the supply warning monitor and the partial power down wake source.
// Assumes the bench sets the supply level and wake requests after clock edges.
`timescale 1ns/1ns
module pmsc_monitor_model
  import pmsc_pkg::*;
#(
  parameter logic [11:0] WARN_LOW_MV = 12'h834,
  parameter logic [11:0] WARN_HIGH_MV = 12'h960
) (
  input wire logic clk_in, // Bus clock.
  input wire logic [11:0] supply_mv_in, // Supply level.
  input wire logic wake_in, // Request one wakeup.
  input wire logic warn_trip_in, // Warning trip select.
  output logic warn_present_out, // Supply below warning point.
  output logic ppd_recovered_out // Wakeup pulse.
);
  // The warning is a level, so it follows the trip select at once.
  assign warn_present_out = supply_mv_in < ((warn_trip_in == PMSC_TRIP_HIGH) ? WARN_HIGH_MV : WARN_LOW_MV);
  always_ff @(posedge clk_in) begin
    ppd_recovered_out <= wake_in;
  end
endmodule : pmsc_monitor_model

//--- bench/pmsc_ctrl2_tb_top.sv
// Self-checking bench for the power management control register.
// Assumes the monitor model and package are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module pmsc_ctrl2_tb_top;
  import pmsc_pkg::*;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic por_reset_in = 1'b1;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic wake = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic [11:0] supply_mv = 12'hc00;
  logic [7:0] rdata_out;
  logic warn_present, ppd_recovered, detect_trip, warn_trip, pd_enable, pd_select;
  always #10 clk_in = ~clk_in;
  // A hang stops the run well past the expected hundred-odd cycles.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  pmsc_ctrl2 pmsc_ctrl2_i (.clk_in(clk_in), .reset_in(reset_in), .por_reset_in(por_reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .warn_present_in(warn_present),
    .ppd_recovered_in(ppd_recovered), .detect_trip_out(detect_trip), .warn_trip_out(warn_trip),
    .power_down_enable_out(pd_enable), .partial_pd_select_out(pd_select));
  pmsc_monitor_model pmsc_monitor_model_i (.clk_in(clk_in), .supply_mv_in(supply_mv), .wake_in(wake),
    .warn_trip_in(warn_trip), .warn_present_out(warn_present), .ppd_recovered_out(ppd_recovered));
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic set_supply(input logic [11:0] v);
    @(posedge clk_in);
    supply_mv <= v;
  endtask : set_supply
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 `CHK(rdata_out, e)
  endtask : rd
  task automatic outs(input logic [3:0] e);
    `CHK({detect_trip, warn_trip, pd_enable, pd_select}, e)
  endtask : outs
  task automatic do_reset(input logic por);
    @(posedge clk_in);
    reset_in <= 1'b1;
    por_reset_in <= por;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    por_reset_in <= 1'b0;
  endtask : do_reset
  task automatic test_write_once();
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h03);
    #1 outs(4'h3);
    wr(4'h0, 8'h30);
    #1 outs(4'hf);
    rd(4'h0, 8'h33);
    rd(4'h5, 8'h00);
    $display("test_write_once done");
  endtask : test_write_once
  task automatic test_warning();
    set_supply(12'h900);
    rd(4'h0, 8'hb3);
    wr(4'h0, 8'h70);
    rd(4'h0, 8'hb3);
    set_supply(12'hc00);
    rd(4'h0, 8'hb3);
    wr(4'h0, 8'h30);
    rd(4'h0, 8'hb3);
    wr(4'h0, 8'h70);
    rd(4'h0, 8'h33);
    wr(4'h0, 8'h20);
    set_supply(12'h900);
    rd(4'h0, 8'h23);
    $display("test_warning done");
  endtask : test_warning
  task automatic test_ppd();
    @(posedge clk_in);
    wake <= 1'b1;
    @(posedge clk_in);
    wake <= 1'b0;
    rd(4'h0, 8'h2b);
    wr(4'h0, 8'h20);
    rd(4'h0, 8'h2b);
    wr(4'h0, 8'h24);
    rd(4'h0, 8'h23);
    // A wakeup that lands on the acknowledge edge must not be lost.
    @(posedge clk_in);
    wake <= 1'b1;
    @(posedge clk_in);
    wake <= 1'b0;
    addr_in <= 4'h0;
    wdata_in <= 8'h24;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd(4'h0, 8'h2b);
    wr(4'h0, 8'h24);
    rd(4'h0, 8'h23);
    $display("test_ppd done");
  endtask : test_ppd
  task automatic test_resets();
    do_reset(1'b0);
    rd(4'h0, 8'h20);
    outs(4'h8);
    set_supply(12'h700);
    do_reset(1'b1);
    rd(4'h0, 8'h80);
    wr(4'h0, 8'h42);
    rd(4'h0, 8'h82);
    outs(4'h2);
    $display("test_resets done");
  endtask : test_resets
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0; por_reset_in <= 1'b0;
    test_write_once();
    test_warning();
    test_ppd();
    test_resets();
    tally_and_finish();
  end
endmodule : pmsc_ctrl2_tb_top
